// File: dpw_ctrl.sv
/* dpw_ctrl: wiper, terminal control and lock state of a one or two channel
   digital pot, with its two-wire bus slave and a local register port.
   assumes scl/sda/address/high-voltage inputs are asynchronous pins and the
   register port master runs on ref_clk. */
// Implementation choices: the plain strobed port and the placing of the registers.
// How it works
// - wiper codes above full scale act as full scale; limits block inc/dec
// - code zero puts wiper on B; full scale code puts it on A
// - a set lock refuses serial changes to that channel's wipers and terminal_control_register
// - locks change only through high-voltage commands
// - reset keeps locks and reloads each wiper from its stored copy
// - shutdown_n low opens terminal A and ties wiper to B
// - shutdown never stops the serial port or stored writes
// - shutdown ignores but keeps the A, W, B connect bits
// - shutdown leaves the wiper untouched; channels shut down separately
// - slave only; the master owns scl, start and stop
// - sda sampled on scl rise; changes only while scl low
// - sda falling while scl high is a start
// - sda rising while scl high is a stop and resets the port
// - works at standard, fast and high-speed bus rates
// - never holds scl low; read data always ready
// - 7-bit addresses and general call only, no 10-bit
// - first byte after start is the slave address byte
// - address is 0101 then pin bits, absent pins read as one
// - accepted byte is acknowledged by pulling sda low one bit
// - after a refusal the master restarts with a new start
// - address pin 0 is latched at reset, live level unused
// - high-voltage flag at start marks a high-voltage command
`timescale 1ns/1ps
module dpw_ctrl #(
  parameter int NCH       = 2,
  parameter int RES_BITS  = dpw_pkg::RES_BITS_DEF,
  parameter int ADDR_PINS = 3
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   sclIn,
  input  wire logic                   sdaIn,
  output logic                        sdaOut,
  output logic                        sdaOe,
  input  wire logic                   addr_pin0,
  input  wire logic                   addr_pin1,
  input  wire logic                   addr_pin2,
  input  wire logic                   high_voltage_command_flag,
  input  wire logic [4:0]             regAddr,
  input  wire logic [31:0]            regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [31:0]                 regRdata,
  output logic [NCH-1:0][8:0]         tapPos,
  output dpw_pkg::dpw_pins_t [NCH-1:0] chanPins
);
  localparam dpw_pkg::dpw_wiper_t FULL    = dpw_pkg::dpw_wiper_t'(1 << RES_BITS);
  localparam dpw_pkg::dpw_wiper_t NVW_DEF = dpw_pkg::dpw_wiper_t'(1 << (RES_BITS - 1));

  if (NCH < 1 || NCH > 2 || RES_BITS < 7 || RES_BITS > 8 || ADDR_PINS < 1
      || ADDR_PINS > 3 || dpw_pkg::HS_BIT_CYC < dpw_pkg::MIN_BIT_CYC) begin : g_bad
    $error("dpw_ctrl: unsupported parameters");
  end

  logic [5:0]                        sync1;
  logic [5:0]                        sync2;
  logic                              sclD;
  logic                              sdaD;
  logic                              scl;
  logic                              sda;
  logic                              sclRise;
  logic                              sclFall;
  logic                              startEv;
  logic                              stopEv;
  logic                              a0Latched;
  logic [6:0]                        ownAddr;
  dpw_pkg::dpw_state_t               state;
  logic [2:0]                        bitCnt;
  logic [6:0]                        shift;
  logic [7:0]                        rxByte;
  logic                              byteDone;
  logic                              opFire;
  logic                              ackNow;
  logic                              ackDrv;
  logic                              isRead;
  logic                              byteIdx;
  logic [7:0]                        ptr;
  logic [7:0]                        txByte;
  logic                              txHi;
  logic                              hsMode;
  logic                              hvMode;
  logic                              gcMode;
  logic                              gcEnable;
  logic                              next_ack;
  logic                              opWr;
  logic                              opInc;
  logic                              opDec;
  logic [3:0]                        opTgt;
  dpw_pkg::dpw_wiper_t               opData;
  dpw_pkg::dpw_wiper_t               rdWord;
  logic [31:0]                       next_regRdata;
  dpw_pkg::dpw_wiper_t [NCH-1:0]     wiper;
  dpw_pkg::dpw_wiper_t [NCH-1:0]     nvw = {NCH{NVW_DEF}};
  dpw_pkg::dpw_terminal_control_register_t [NCH-1:0]      terminal_control_register;
  logic [NCH-1:0]                    lock = '0;

  function automatic logic chanOf(input logic [3:0] t);
    return t == dpw_pkg::TGT_WIPER1 || t == dpw_pkg::TGT_NVW1;
  endfunction

  function automatic logic tgtValid(input logic [3:0] t);
    return t <= dpw_pkg::TGT_LOCK && !(chanOf(t) && NCH < 2);
  endfunction

  function automatic logic locked(input logic [3:0] t);
    return chanOf(t) ? lock[NCH-1] : lock[0];
  endfunction

  // pins pass two flops; the second stage and its third-stage delayed copy both feed edge detection
  always_ff @(posedge ref_clk) begin
    sync1 <= {high_voltage_command_flag, addr_pin2, addr_pin1, addr_pin0, sdaIn, sclIn};
    sync2 <= sync1;
    sclD  <= sync2[0];
    sdaD  <= sync2[1];
  end

  assign scl     = sync2[0];
  assign sda     = sync2[1];
  assign sclRise = scl && !sclD;
  assign sclFall = !scl && sclD;
  assign startEv = scl && sclD && sdaD && !sda;
  assign stopEv  = scl && sclD && !sdaD && sda;

  // pin 0 doubles as the high-voltage input, so only its reset level counts
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      a0Latched <= sync2[2];
    end
  end

  // pins 2 and 1 are read live and must not move during traffic
  assign ownAddr = {dpw_pkg::DEV_CODE,
                    (ADDR_PINS > 2) ? sync2[4] : 1'b1,
                    (ADDR_PINS > 1) ? sync2[3] : 1'b1,
                    a0Latched};

  assign rxByte   = {shift, sda};
  assign byteDone = sclRise && bitCnt == 3'h7 && (state == dpw_pkg::ST_ADDR
                    || state == dpw_pkg::ST_RX);
  assign opFire   = byteDone && state == dpw_pkg::ST_RX;

  always_comb begin
    next_ack = 1'b0;
    opWr     = 1'b0;
    opInc    = 1'b0;
    opDec    = 1'b0;
    opTgt    = rxByte[7:4];
    opData   = {rxByte[1:0], 8'h00};
    if (state == dpw_pkg::ST_ADDR) begin
      // 10-bit headers and the hs master code never match
      next_ack = rxByte[7:1] == ownAddr
                 || (rxByte[7:1] == dpw_pkg::GCALL_ADDR && !rxByte[0] && gcEnable);
    end else if (gcMode) begin
      next_ack = 1'b0;
    end else if (!byteIdx) begin
      unique case (rxByte[3:2])
        dpw_pkg::CMD_INC, dpw_pkg::CMD_DEC: begin
          next_ack = tgtValid(opTgt) && !locked(opTgt)
                     && (opTgt == dpw_pkg::TGT_WIPER0 || opTgt == dpw_pkg::TGT_WIPER1);
          opInc    = next_ack && rxByte[3:2] == dpw_pkg::CMD_INC;
          opDec    = next_ack && rxByte[3:2] == dpw_pkg::CMD_DEC;
        end
        dpw_pkg::CMD_WRITE, dpw_pkg::CMD_READ: begin
          next_ack = tgtValid(opTgt);
        end
      endcase
    end else begin
      opTgt    = ptr[7:4];
      opData   = {ptr[1:0], rxByte};
      if (opTgt == dpw_pkg::TGT_LOCK) begin
        next_ack = hvMode;
      end else begin
        next_ack = tgtValid(opTgt) && (opTgt == dpw_pkg::TGT_TERMINAL_CONTROL_REGISTER || !locked(opTgt));
      end
      opWr     = next_ack;
    end
  end

  // serial bit engine; sda only ever pulled low, scl never driven
  always_ff @(posedge ref_clk) begin
    if (sys_rst || stopEv) begin
      state   <= dpw_pkg::ST_IDLE;
      bitCnt  <= 3'h0;
      shift   <= 7'h00;
      sdaOe   <= 1'b0;
      ackNow  <= 1'b0;
      ackDrv  <= 1'b0;
      isRead  <= 1'b0;
      byteIdx <= 1'b0;
      ptr     <= 8'h00;
      txByte  <= 8'h00;
      txHi    <= 1'b0;
      hsMode  <= 1'b0;
      hvMode  <= 1'b0;
      gcMode  <= 1'b0;
    end else if (startEv) begin
      state   <= dpw_pkg::ST_ADDR;
      bitCnt  <= 3'h0;
      sdaOe   <= 1'b0;
      ackDrv  <= 1'b0;
      byteIdx <= 1'b0;
      gcMode  <= 1'b0;
      hvMode  <= sync2[5];
    end else begin
      unique case (state)
        dpw_pkg::ST_IDLE: begin
          sdaOe <= 1'b0;
        end
        dpw_pkg::ST_ADDR, dpw_pkg::ST_RX: begin
          if (sclRise) begin
            shift  <= rxByte[6:0];
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              ackNow <= next_ack;
              if (state == dpw_pkg::ST_ADDR) begin
                state  <= dpw_pkg::ST_ACKA;
                isRead <= rxByte[0];
                gcMode <= rxByte[7:1] == dpw_pkg::GCALL_ADDR;
                hsMode <= hsMode || rxByte[7:3] == dpw_pkg::HS_CODE;
                // read data is ready before the ack ends: no stretching
                txByte <= {6'h00, rdWord[9:8]};
                txHi   <= 1'b0;
              end else begin
                state   <= dpw_pkg::ST_ACKR;
                byteIdx <= !byteIdx && rxByte[3:2] == dpw_pkg::CMD_WRITE && next_ack;
                if (!byteIdx) begin
                  ptr <= rxByte;
                end
              end
            end
          end
        end
        dpw_pkg::ST_ACKA, dpw_pkg::ST_ACKR: begin
          if (sclFall) begin
            if (!ackDrv) begin
              sdaOe  <= ackNow;
              ackDrv <= 1'b1;
            end else begin
              ackDrv <= 1'b0;
              bitCnt <= 3'h0;
              if (!ackNow) begin
                sdaOe <= 1'b0;
                state <= dpw_pkg::ST_IDLE;
              end else if (state == dpw_pkg::ST_ACKA && isRead) begin
                sdaOe <= !txByte[7];
                state <= dpw_pkg::ST_TX;
              end else begin
                sdaOe <= 1'b0;
                state <= dpw_pkg::ST_RX;
              end
            end
          end
        end
        dpw_pkg::ST_TX: begin
          if (sclFall) begin
            sdaOe <= !txByte[7];
          end else if (sclRise) begin
            txByte <= {txByte[6:0], 1'b0};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              state <= dpw_pkg::ST_ACKT;
            end
          end
        end
        dpw_pkg::ST_ACKT: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
          end else if (sclRise) begin
            bitCnt <= 3'h0;
            txByte <= txHi ? {6'h00, rdWord[9:8]} : rdWord[7:0];
            txHi   <= !txHi;
            state  <= sda ? dpw_pkg::ST_IDLE : dpw_pkg::ST_TX;
          end
        end
        default: begin
          state <= dpw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    sdaOut <= 1'b0;
  end

  always_comb begin
    unique case (ptr[7:4])
      dpw_pkg::TGT_WIPER0: rdWord = wiper[0];
      dpw_pkg::TGT_WIPER1: rdWord = wiper[NCH-1];
      dpw_pkg::TGT_NVW0:   rdWord = nvw[0];
      dpw_pkg::TGT_NVW1:   rdWord = nvw[NCH-1];
      dpw_pkg::TGT_TERMINAL_CONTROL_REGISTER:   rdWord = dpw_pkg::dpw_wiper_t'(terminal_control_register);
      dpw_pkg::TGT_LOCK:   rdWord = dpw_pkg::dpw_wiper_t'(lock);
      default:             rdWord = '0;
    endcase
  end

  // volatile wipers and terminal_control_register; shutdown does not gate serial writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wiper <= nvw;
      terminal_control_register  <= {NCH{dpw_pkg::TERMINAL_CONTROL_REGISTER_RST}};
    end else if (opFire) begin
      for (int c = 0; c < NCH; c++) begin
        if (opInc && chanOf(opTgt) == c[0] && wiper[c] < FULL) begin
          wiper[c] <= wiper[c] + 10'h001;
        end
        if (opDec && chanOf(opTgt) == c[0] && wiper[c] != '0 && wiper[c] <= FULL) begin
          wiper[c] <= wiper[c] - 10'h001;
        end
        if (opWr && opTgt == (c[0] ? dpw_pkg::TGT_WIPER1 : dpw_pkg::TGT_WIPER0)) begin
          wiper[c] <= opData;
        end
        // a locked channel keeps its nibble even in a shared terminal_control_register write
        if (opWr && opTgt == dpw_pkg::TGT_TERMINAL_CONTROL_REGISTER && !lock[c]) begin
          terminal_control_register[c] <= opData[4*c +: 4];
        end
      end
    end
  end

  // stored wipers survive reset; serial wins over a same-cycle bus write
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (opFire && opWr && opTgt == (c[0] ? dpw_pkg::TGT_NVW1 : dpw_pkg::TGT_NVW0)) begin
        nvw[c] <= opData;
      end else if (regWr && regAddr == (c[0] ? dpw_pkg::OFS_NVW1 : dpw_pkg::OFS_NVW0)) begin
        nvw[c] <= regWdata[9:0];
      end
    end
  end

  // locks are non-volatile: no reset term at all
  always_ff @(posedge ref_clk) begin
    if (opFire && opWr && opTgt == dpw_pkg::TGT_LOCK) begin
      lock <= opData[NCH-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gcEnable <= dpw_pkg::GCEN_RST;
    end else if (regWr && regAddr == dpw_pkg::OFS_CFG) begin
      gcEnable <= regWdata[dpw_pkg::CFG_GCEN_BIT];
    end
  end

  // terminal outputs per channel, each shut down on its own
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tapPos   <= '0;
      chanPins <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        tapPos[c] <= (wiper[c] > FULL) ? FULL[8:0] : wiper[c][8:0];
        if (!terminal_control_register[c].chan_shutdown_n) begin
          chanPins[c] <= '{chan_terminal_a_pin: 1'b0, chan_wiper_pin: 1'b1,
                           chan_terminal_b_pin: 1'b1, wiper_to_b: 1'b1};
        end else begin
          chanPins[c] <= '{chan_terminal_a_pin: terminal_control_register[c].chan_term_a_connect,
                           chan_wiper_pin: terminal_control_register[c].chan_wiper_connect,
                           chan_terminal_b_pin: terminal_control_register[c].chan_term_b_connect,
                           wiper_to_b: 1'b0};
        end
      end
    end
  end

  always_comb begin
    next_regRdata = 32'h0000_0000;
    unique case (regAddr)
      dpw_pkg::OFS_WIPER0: next_regRdata = 32'(wiper[0]);
      dpw_pkg::OFS_WIPER1: next_regRdata = (NCH > 1) ? 32'(wiper[NCH-1]) : 32'h0000_0000;
      dpw_pkg::OFS_TERMINAL_CONTROL_REGISTER:   next_regRdata = 32'(terminal_control_register);
      dpw_pkg::OFS_STATUS: begin
        next_regRdata[NCH-1:0]              = lock;
        next_regRdata[dpw_pkg::ST_HS_BIT]   = hsMode;
        next_regRdata[dpw_pkg::ST_HV_BIT]   = hvMode;
        next_regRdata[dpw_pkg::ST_A0_BIT]   = a0Latched;
        next_regRdata[dpw_pkg::ST_BUSY_BIT] = state != dpw_pkg::ST_IDLE;
      end
      dpw_pkg::OFS_NVW0:   next_regRdata = 32'(nvw[0]);
      dpw_pkg::OFS_NVW1:   next_regRdata = (NCH > 1) ? 32'(nvw[NCH-1]) : 32'h0000_0000;
      dpw_pkg::OFS_CFG:    next_regRdata[dpw_pkg::CFG_GCEN_BIT] = gcEnable;
      default:             next_regRdata = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !regRd) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ackStart;
    (state == dpw_pkg::ST_ACKA || state == dpw_pkg::ST_ACKR) && sclFall && !ackDrv && ackNow;
  endsequence
  sequence s_stopped;
    state == dpw_pkg::ST_IDLE && !sdaOe;
  endsequence

  property p_tapFull;
    wiper[0] > FULL |=> tapPos[0] == FULL[8:0];
  endproperty
  property p_incTop;
    opFire && opInc && !chanOf(opTgt) && wiper[0] >= FULL |=> wiper[0] == $past(wiper[0]);
  endproperty
  property p_zeroB;
    wiper[0] == '0 |=> tapPos[0] == 9'h000;
  endproperty
  property p_lockHold;
    lock[0] && opFire |=> $stable(wiper[0]) && $stable(terminal_control_register[0]);
  endproperty
  property p_lockHv;
    !hvMode |=> $stable(lock);
  endproperty
  property p_shdn;
    !terminal_control_register[0].chan_shutdown_n |=> !chanPins[0].chan_terminal_a_pin && chanPins[0].wiper_to_b;
  endproperty
  property p_resume;
    terminal_control_register[0].chan_shutdown_n |=> !chanPins[0].wiper_to_b
      && chanPins[0].chan_terminal_a_pin == $past(terminal_control_register[0].chan_term_a_connect);
  endproperty
  property p_sdaStable;
    scl && !startEv && !stopEv |=> $stable(sdaOe);
  endproperty
  property p_ack;
    s_ackStart |=> sdaOe;
  endproperty
  property p_stop;
    stopEv |=> s_stopped;
  endproperty
  property p_start;
    startEv |=> state == dpw_pkg::ST_ADDR && hvMode == $past(sync2[5]);
  endproperty

  a_tapFull: assert property (p_tapFull) else $error("tap not clamped");
  a_incTop: assert property (p_incTop) else $error("inc past full scale");
  a_zeroB: assert property (p_zeroB) else $error("zero code not on B");
  a_lockHold: assert property (p_lockHold) else $error("locked state moved");
  a_lockHv: assert property (p_lockHv) else $error("lock changed without hv");
  a_shdn: assert property (p_shdn) else $error("shutdown pins wrong");
  a_resume: assert property (p_resume) else $error("terminal_control_register not governing");
  a_sdaStable: assert property (p_sdaStable) else $error("sda moved with scl high");
  a_ack: assert property (p_ack) else $error("ack not driven");
  a_stop: assert property (p_stop) else $error("stop did not reset port");
  a_start: assert property (p_start) else $error("start not taken");
endmodule // dpw_ctrl

// File: dpw_pkg.sv
/* dpw_pkg: constants and types shared by the digipot wiper controller.
   assumes a single 40 MHz system clock drives every user of this package. */
package dpw_pkg;
  localparam int         WIPER_W      = 10;
  localparam int         RES_BITS_DEF = 8;
  // clock rate and fastest bus rate, both in kHz; cycles per fastest bit
  localparam int         CLK_KHZ      = 40000;
  localparam int         HS_MAX_KHZ   = 3400;
  localparam int         HS_BIT_CYC   = CLK_KHZ / HS_MAX_KHZ;
  localparam int         MIN_BIT_CYC  = 8;
  // register bus byte offsets
  localparam logic [4:0] OFS_WIPER0   = 5'h00;
  localparam logic [4:0] OFS_WIPER1   = 5'h04;
  localparam logic [4:0] OFS_TERMINAL_CONTROL_REGISTER     = 5'h08;
  localparam logic [4:0] OFS_STATUS   = 5'h0C;
  localparam logic [4:0] OFS_NVW0     = 5'h10;
  localparam logic [4:0] OFS_NVW1     = 5'h14;
  localparam logic [4:0] OFS_CFG      = 5'h18;
  // status and config field positions
  localparam int         ST_HS_BIT    = 2;
  localparam int         ST_HV_BIT    = 3;
  localparam int         ST_A0_BIT    = 4;
  localparam int         ST_BUSY_BIT  = 5;
  localparam int         CFG_GCEN_BIT = 0;
  // reset values
  localparam logic [3:0] TERMINAL_CONTROL_REGISTER_RST     = 4'hF;
  localparam logic       GCEN_RST     = 1'b0;
  // bus addressing
  localparam logic [3:0] DEV_CODE     = 4'h5;
  localparam logic [6:0] GCALL_ADDR   = 7'h00;
  localparam logic [4:0] HS_CODE      = 5'h01;
  // serial pointer byte: [7:4] target, [3:2] command, [1:0] data bits 9:8
  localparam logic [3:0] TGT_WIPER0   = 4'h0;
  localparam logic [3:0] TGT_WIPER1   = 4'h1;
  localparam logic [3:0] TGT_NVW0     = 4'h2;
  localparam logic [3:0] TGT_NVW1     = 4'h3;
  localparam logic [3:0] TGT_TERMINAL_CONTROL_REGISTER     = 4'h4;
  localparam logic [3:0] TGT_LOCK     = 4'h5;
  localparam logic [1:0] CMD_WRITE    = 2'h0;
  localparam logic [1:0] CMD_INC      = 2'h1;
  localparam logic [1:0] CMD_DEC      = 2'h2;
  localparam logic [1:0] CMD_READ     = 2'h3;

  typedef logic [WIPER_W-1:0] dpw_wiper_t;

  typedef struct packed {
    logic chan_shutdown_n;
    logic chan_term_a_connect;
    logic chan_wiper_connect;
    logic chan_term_b_connect;
  } dpw_terminal_control_register_t;

  typedef struct packed {
    logic chan_terminal_a_pin;
    logic chan_wiper_pin;
    logic chan_terminal_b_pin;
    logic wiper_to_b;
  } dpw_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACKA = 3'h3,
    ST_RX   = 3'h2,
    ST_ACKR = 3'h6,
    ST_TX   = 3'h7,
    ST_ACKT = 3'h5
  } dpw_state_t;
endpackage

// File: dpw_i2c_master.sv
/* dpw_i2c_master: behavioural two-wire bus master facing the wiper controller.
   assumes the bench resolves sda with a pull-up; moves only after ref_clk rises. */
`timescale 1ns/1ps
module dpw_i2c_master (
  input  wire logic ref_clk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaLow,
  output logic      hvFlag
);
  // every sampled byte bit of the last frame, read data included; ack bits go to acks
  logic [23:0] rxBits;
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    hvFlag = 1'b0;
  end
  // sda moves one clock after scl falls, so no false start or stop appears
  task automatic lowPhase(input logic pull);
    @(posedge ref_clk);
    sdaLow <= pull;
    repeat (3) @(posedge ref_clk);
    sclOut <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic oneBit(input logic b, output logic s);
    lowPhase(!b);
    s = sdaWire;
    sclOut <= 1'b0;
  endtask
  // every frame opens with a fresh start, so a refused one leaves no state
  task automatic frame(input logic hv, input logic [7:0] ad, p, d, output logic [2:0] acks);
    logic [23:0] sh;
    logic        s;
    sh = {ad, p, d};
    hvFlag <= hv;
    lowPhase(1'b0);
    sdaLow <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sclOut <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 8; i++) begin
        oneBit(sh[23-8*k-i], s);
        rxBits[23-8*k-i] = s;
      end
      oneBit(1'b1, s);
      acks[2-k] = !s;
    end
    hvFlag <= 1'b0;
    lowPhase(1'b1);
    sdaLow <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // dpw_i2c_master

// File: test_dpw_ctrl.sv
/* test_dpw_ctrl: self-checking bench for dpw_ctrl over the serial bus and register port.
   assumes dpw_i2c_master on the far side and a pull-up on sda. */
`timescale 1ns/1ps
module test_dpw_ctrl;
  logic ref_clk, sys_rst, sclOut, sdaLow, hvFlag, sdaOut, sdaOe, sdaWire, addr_pin0, regWr, regRd;
  logic [4:0]                regAddr;
  logic [31:0]               regWdata, regRdata;
  logic [1:0][8:0]           tapPos;
  dpw_pkg::dpw_pins_t [1:0]  chanPins;
  logic [2:0]                acks;
  int                        bad_count = 0;
  int                        checks_done = 0;
  assign sdaWire = !sdaLow && !(sdaOe && !sdaOut);
  // address pins 2 and 1 stay tied
  dpw_ctrl i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclIn(sclOut), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_pin0(addr_pin0), .addr_pin1(1'b1), .addr_pin2(1'b0),
    .high_voltage_command_flag(hvFlag), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tapPos(tapPos), .chanPins(chanPins));
  dpw_i2c_master i_mst (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclOut),
    .sdaLow(sdaLow), .hvFlag(hvFlag));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read data is sampled at the edge that ends its single cycle
  task automatic reg_(input logic wr, input logic [4:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= wr;
    regRd <= !wr;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic tAddr();
    addr_pin0 <= 1'b0;
    i_mst.frame(1'b0, 8'h54, 8'h01, 8'h00, acks);
    check(acks, 3'h0);
    i_mst.frame(1'b0, 8'h56, 8'h01, 8'h00, acks);
    check(acks, 3'h7);
    check(tapPos[0], 9'h100);
    reg_(1'b0, dpw_pkg::OFS_STATUS, 32'h0);
    check(regRdata, 32'h10);
    check(tapPos[1], 9'h080);
    i_mst.frame(1'b0, 8'h00, 8'h00, 8'h00, acks);
    check(acks, 3'h0);
    reg_(1'b1, dpw_pkg::OFS_CFG, 32'h1);
    i_mst.frame(1'b0, 8'h00, 8'h00, 8'h00, acks);
    check(acks, 3'h4);
    i_mst.frame(1'b0, 8'hF0, 8'h00, 8'h00, acks);
    check(acks, 3'h0);
    i_mst.frame(1'b0, 8'h08, 8'h00, 8'h00, acks);
    check(acks, 3'h0);
  endtask
  task automatic tScale();
    i_mst.frame(1'b0, 8'h56, 8'h03, 8'hFF, acks);
    i_mst.frame(1'b0, 8'h56, 8'h04, 8'h04, acks);
    check(acks, 3'h7);
    reg_(1'b0, dpw_pkg::OFS_WIPER0, 32'h0);
    check(regRdata, 32'h3FF);
    i_mst.frame(1'b0, 8'h57, 8'hFF, 8'hFF, acks);
    check(acks, 3'h4);
    check(i_mst.rxBits[15:8], 8'h03);
    check(tapPos[0], 9'h100);
    i_mst.frame(1'b0, 8'h56, 8'h00, 8'h00, acks);
    i_mst.frame(1'b0, 8'h56, 8'h08, 8'h08, acks);
    check(tapPos[0], 9'h000);
  endtask
  task automatic tShdn();
    i_mst.frame(1'b0, 8'h56, 8'h40, 8'hF7, acks);
    check(acks, 3'h7);
    check({chanPins[0][3], chanPins[0][0]}, 2'h1);
    check(chanPins[1], 4'hE);
    reg_(1'b0, dpw_pkg::OFS_TERMINAL_CONTROL_REGISTER, 32'h0);
    check(regRdata, 32'hF7);
    i_mst.frame(1'b0, 8'h56, 8'h40, 8'hFF, acks);
    check(chanPins[0], 4'hE);
  endtask
  task automatic tReset();
    reg_(1'b1, dpw_pkg::OFS_NVW0, 32'h55);
    addr_pin0 <= 1'b1;
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reg_(1'b0, dpw_pkg::OFS_WIPER0, 32'h0);
    check(regRdata, 32'h55);
    reg_(1'b0, 5'h1C, 32'h0);
    check(regRdata, 32'h0);
  endtask
  task automatic tLock();
    i_mst.frame(1'b0, 8'h56, 8'h50, 8'h03, acks);
    check(acks, 3'h6);
    i_mst.frame(1'b1, 8'h56, 8'h50, 8'h03, acks);
    check(acks, 3'h7);
    i_mst.frame(1'b0, 8'h56, 8'h00, 8'h10, acks);
    check(acks, 3'h6);
    reg_(1'b0, dpw_pkg::OFS_WIPER0, 32'h0);
    check(regRdata, 32'h55);
    i_mst.frame(1'b0, 8'h56, 8'h20, 8'h11, acks);
    check(acks, 3'h6);
    reg_(1'b0, dpw_pkg::OFS_NVW0, 32'h0);
    check(regRdata, 32'h55);
    i_mst.frame(1'b0, 8'h56, 8'h40, 8'h00, acks);
    check(acks, 3'h7);
    check(chanPins[0], 4'hE);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reg_(1'b0, dpw_pkg::OFS_STATUS, 32'h0);
    check(regRdata, 32'h13);
  endtask
  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    addr_pin0 = 1'b1;
    regAddr = 5'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tAddr();
    tScale();
    tShdn();
    tReset();
    tLock();
    results();
  end
endmodule // test_dpw_ctrl
